// file: endec_pkg.sv
// Purpose: Shared constants and types for the 10 Mb/s line coding and link logic.
// Assumes: ref_clk at 40 MHz, one bit time is four clock cycles.
// Notes: Register numbers double as port addresses on the plain register port.
package endec_pkg;

    localparam int CLK_NS = 25;
    localparam int BIT_NS = 100;
    localparam int CYC_PER_BIT = BIT_NS / CLK_NS;
    localparam int NS_PER_MS = 1000000;

    // Carrier release window in tenths of a bit time after the last line edge.
    localparam int CRS_OFF_MIN_TENTHS = 13;
    localparam int CRS_OFF_MAX_TENTHS = 23;
    // The edge counter lags the pins by the synchroniser stages, so they come off the count.
    localparam int RX_SYNC_CYC = 2;
    localparam logic [3:0] CRS_OFF_CYC =
        4'((CRS_OFF_MIN_TENTHS * BIT_NS + 10 * CLK_NS - 1) / (10 * CLK_NS) - RX_SYNC_CYC);
    localparam logic [3:0] CRS_OFF_LIMIT = 4'((CRS_OFF_MAX_TENTHS * BIT_NS) / (10 * CLK_NS));
    localparam logic [3:0] MID_MIN_CYC = 4'((3 * CYC_PER_BIT) / 4);
    localparam logic [3:0] LP_MAX_CYC = 4'(2 * CYC_PER_BIT);
    localparam logic [3:0] CI_HOLD_CYC = 4'(2 * CYC_PER_BIT);
    localparam logic [1:0] BIT_LAST = 2'(CYC_PER_BIT - 1);
    localparam logic [1:0] BIT_HALF = 2'(CYC_PER_BIT / 2);
    localparam logic [2:0] LP_LEN = 3'(CYC_PER_BIT);
    localparam logic [2:0] POL_FRAMES = 3'h4;
    localparam logic [3:0] PAT_A = 4'hA;
    localparam logic [3:0] PAT_B = 4'h5;

    localparam int LINK_PULSE_MS = 16;
    localparam int LINK_LOSS_MS = 50;
    localparam int LP_MIN_GAP_MS = 4;

    localparam logic [4:0] REG_TX_EVENT = 5'h08;
    localparam logic [4:0] REG_LINE_CTL = 5'h0D;
    localparam logic [4:0] REG_LINE_ST = 5'h0E;
    localparam logic [4:0] REG_SELF_CTL = 5'h0F;
    localparam logic [4:0] REG_TEST_CTL = 5'h13;

    localparam int BIT_AUI_ONLY = 8;
    localparam int BIT_AUTO_SEL = 9;
    localparam int BIT_POL_DIS = 12;
    localparam int BIT_EXT_RANGE = 14;
    localparam int BIT_ST_LINK = 7;
    localparam int BIT_ST_POL = 12;
    localparam int BIT_ST_CRS = 14;
    localparam int BIT_LED_OVR = 13;
    localparam int BIT_LED_MAN = 14;
    localparam int BIT_LT_DIS = 7;
    localparam int BIT_FDX = 14;
    localparam int BIT_EV_LOSS = 6;

    localparam logic [15:0] LINE_CTL_RST = 16'h0000;
    localparam logic [15:0] SELF_CTL_RST = 16'h0000;
    localparam logic [15:0] TEST_CTL_RST = 16'h0000;

    typedef enum logic [1:0] {
        LINK_BAD = 2'h0,
        LINK_ARMED = 2'h1,
        LINK_GOOD = 2'h3
    } link_state_t;

endpackage

// file: ten_mbit_endec_link_logic.sv
// Purpose: Manchester encoder, carrier detect, decoder, port select, link integrity,
//          polarity correction and collision logic of a 10 Mb/s attachment.
// Assumes: Line receivers deliver sliced positive and negative levels per port.
// Notes: Pins pass two flip-flops before use; all outputs are registered.
//
// Overview of operation
// (R1) Manchester-encode MAC data onto selected port.
// (R2) Carrier on 1010/0101 twisted pair, any AUI bit.
// (R3) Carrier holds, drops 1.3-2.3 bits after last edge.
// (R4) Status register shows live carrier sense.
// (R5) Idle clock tracks internal; relocks to data.
// (R6) Line control bits 8 and 9 choose port.
// (R7) Unused fixed port is powered down.
// (R8) Auto mode prefers twisted pair when active.
// (R9) Idle twisted pair sends one-bit link pulses.
// (R10) Link pulse timer restarts at end of frame.
// (R11) No received pulses forces transmitter inactive.
// (R12) Extended range lowers receive squelch threshold.
// (R13) Link-loss timer expiry stops packet transmission.
// (R14) Packet or two spaced pulses restore link.
// (R15) Link status bit and active-low link LED.
// (R16) Link test disable ignores link state.
// (R17) Polarity status and correction disable act independently.
// (R18) Reversal needs pulse plus four reversed frames.
// (R19) Half duplex collision on simultaneous transmit, receive.
// (R20) AUI carrier missing or lost flags event.
// (R21) AUI collision pair asserts MAC collision.
// (R22) All timing counted in clock cycles.
// (R23) Reset: link bad, polarity good, timer running.
`timescale 1ns/1ps
module ten_mbit_endec_link_logic #(
    parameter int TW = 22,
    parameter int LP_PERIOD_CYC = endec_pkg::LINK_PULSE_MS * endec_pkg::NS_PER_MS / endec_pkg::CLK_NS,
    parameter int LINK_LOSS_CYC = endec_pkg::LINK_LOSS_MS * endec_pkg::NS_PER_MS / endec_pkg::CLK_NS,
    parameter int LP_MIN_GAP_CYC = endec_pkg::LP_MIN_GAP_MS * endec_pkg::NS_PER_MS / endec_pkg::CLK_NS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic mac_tx_en,
    input wire logic mac_tx_data,
    output logic tx_bit_taken,
    output logic mac_rx_data,
    output logic mac_rx_valid,
    output logic mac_rx_clk,
    output logic mac_crs,
    output logic mac_col,
    input wire logic tp_rx_pos,
    input wire logic tp_rx_neg,
    output logic tp_tx_out,
    output logic tp_tx_en,
    output logic tp_power_down,
    output logic tp_low_squelch,
    input wire logic aui_rx_pos,
    input wire logic aui_rx_neg,
    input wire logic aui_ci,
    output logic aui_tx_out,
    output logic aui_tx_en,
    output logic aui_power_down,
    output logic link_led_out
);

    typedef struct packed {
        logic [15:0] line_ctl;
        logic [15:0] self_ctl;
        logic [15:0] test_ctl;
        logic carrier_lost_flag;
        logic [15:0] rdata;
        logic tpp1, tpp2, tpn1, tpn2;
        logic aip1, aip2, ain1, ain2;
        logic ci1, ci2;
        logic tp_sel, tp_pd, aui_pd, low_sq, led;
        logic in_burst, saw_p, saw_n, raw_last;
        logic [3:0] blen;
        logic reversed, rev_lp, good_lp;
        logic [2:0] rev_frames, good_frames;
        logic lvl;
        logic [3:0] since_edge, since_mid, pat;
        logic crs, rx_data, rx_valid, rx_clk;
        endec_pkg::link_state_t link_st;
        logic [TW-1:0] loss_cnt, gap_cnt, lp_cnt;
        logic [1:0] phase;
        logic tx_on, tx_bit, taken;
        logic [2:0] lp_len;
        logic tp_out, tp_en, aui_out, aui_en;
        logic [3:0] ci_cnt;
        logic col, aui_crs_seen;
    } st_t;

    st_t st_q, st_d;

    logic aui_only, auto_sel, pol_dis, link_ok, tp_act, lp_ev, pkt_ev;
    logic swap, p, n, act, lvl_now, edge_ev, bit_ev, discard;
    logic take, eof, line, tp_pkt, aui_tx, loss_set;

    always_comb begin
        st_d = st_q;
        lp_ev = 1'b0;
        pkt_ev = 1'b0;
        loss_set = 1'b0;
        // Pin synchronisers; the first stage feeds only the second.
        st_d.tpp1 = tp_rx_pos;
        st_d.tpp2 = st_q.tpp1;
        st_d.tpn1 = tp_rx_neg;
        st_d.tpn2 = st_q.tpn1;
        st_d.aip1 = aui_rx_pos;
        st_d.aip2 = st_q.aip1;
        st_d.ain1 = aui_rx_neg;
        st_d.ain2 = st_q.ain1;
        st_d.ci1 = aui_ci;
        st_d.ci2 = st_q.ci1;

        aui_only = st_q.line_ctl[endec_pkg::BIT_AUI_ONLY];
        auto_sel = st_q.line_ctl[endec_pkg::BIT_AUTO_SEL];
        pol_dis = st_q.line_ctl[endec_pkg::BIT_POL_DIS];
        link_ok = (st_q.link_st == endec_pkg::LINK_GOOD) ||
            st_q.test_ctl[endec_pkg::BIT_LT_DIS]; // R16
        st_d.tp_sel = !aui_only && (!auto_sel || st_q.link_st == endec_pkg::LINK_GOOD); // R6 R8
        st_d.tp_pd = aui_only; // R7
        st_d.aui_pd = st_d.tp_sel; // R7 R8
        st_d.low_sq = st_q.line_ctl[endec_pkg::BIT_EXT_RANGE]; // R12
        st_d.led = st_q.self_ctl[endec_pkg::BIT_LED_OVR] ?
            st_q.self_ctl[endec_pkg::BIT_LED_MAN] : (st_q.link_st != endec_pkg::LINK_GOOD); // R15

        // The twisted-pair receiver always listens, even while the AUI carries traffic.
        tp_act = st_q.tpp2 || st_q.tpn2;
        if (tp_act) begin
            st_d.in_burst = 1'b1;
            st_d.saw_p = st_q.saw_p || st_q.tpp2;
            st_d.saw_n = st_q.saw_n || st_q.tpn2;
            st_d.raw_last = st_q.tpp2;
            if (st_q.blen != 4'hF) begin
                st_d.blen = st_q.blen + 4'h1;
            end
        end else if (st_q.in_burst) begin
            st_d.in_burst = 1'b0;
            st_d.saw_p = 1'b0;
            st_d.saw_n = 1'b0;
            st_d.blen = 4'h0;
            if (st_q.blen <= endec_pkg::LP_MAX_CYC) begin
                lp_ev = 1'b1;
                if (st_q.saw_p && !st_q.saw_n) begin
                    st_d.good_lp = 1'b1;
                    st_d.rev_lp = 1'b0;
                end else if (st_q.saw_n && !st_q.saw_p) begin
                    st_d.rev_lp = 1'b1; // R18
                    st_d.good_lp = 1'b0;
                end
            end else begin
                pkt_ev = 1'b1;
                // A frame ends on a positive idle level unless the pair is crossed.
                if (st_q.raw_last) begin
                    st_d.rev_frames = 3'h0;
                    if (st_q.good_frames != endec_pkg::POL_FRAMES) begin
                        st_d.good_frames = st_q.good_frames + 3'h1;
                    end
                end else begin
                    st_d.good_frames = 3'h0; // R18
                    if (st_q.rev_frames != endec_pkg::POL_FRAMES) begin
                        st_d.rev_frames = st_q.rev_frames + 3'h1;
                    end
                end
            end
        end
        if (!st_q.reversed && st_d.rev_lp && st_d.rev_frames == endec_pkg::POL_FRAMES) begin
            st_d.reversed = 1'b1; // R18
            st_d.rev_frames = 3'h0;
        end else if (st_q.reversed && st_d.good_lp &&
                     st_d.good_frames == endec_pkg::POL_FRAMES) begin
            st_d.reversed = 1'b0;
            st_d.good_frames = 3'h0;
        end

        // Decoder on the selected port; polarity fix only applies to the twisted pair.
        swap = st_q.reversed && !pol_dis && st_q.tp_sel; // R17
        p = st_q.tp_sel ? st_q.tpp2 : st_q.aip2;
        n = st_q.tp_sel ? st_q.tpn2 : st_q.ain2;
        act = p || n;
        lvl_now = act ? (p ^ swap) : st_q.lvl;
        edge_ev = act && (lvl_now != st_q.lvl);
        bit_ev = edge_ev && (st_q.since_mid >= endec_pkg::MID_MIN_CYC); // R5
        st_d.lvl = lvl_now;
        if (edge_ev) begin
            st_d.since_edge = 4'h0;
        end else if (st_q.since_edge != 4'hF) begin
            st_d.since_edge = st_q.since_edge + 4'h1;
        end
        if (bit_ev) begin
            st_d.since_mid = 4'h0;
            st_d.pat = {st_q.pat[2:0], lvl_now};
        end else if (st_q.since_mid != 4'hF) begin
            st_d.since_mid = st_q.since_mid + 4'h1;
        end
        if (!st_q.crs && bit_ev && (!st_q.tp_sel || st_d.pat == endec_pkg::PAT_A ||
                                    st_d.pat == endec_pkg::PAT_B)) begin
            st_d.crs = 1'b1; // R2
        end else if (st_q.crs && st_q.since_edge >= endec_pkg::CRS_OFF_CYC) begin
            st_d.crs = 1'b0; // R3
            st_d.pat = 4'h0;
        end
        // Data seen while a reversal is suspected but not yet fixed would be inverted.
        discard = st_q.tp_sel && !pol_dis && !st_q.reversed &&
            (st_q.rev_lp || st_q.rev_frames != 3'h0); // R18
        st_d.rx_valid = bit_ev && st_d.crs && link_ok && !discard; // R5 R14
        st_d.rx_data = lvl_now;
        st_d.rx_clk = st_q.crs ? (st_q.since_mid < 4'(endec_pkg::BIT_HALF)) :
            (st_q.phase < endec_pkg::BIT_HALF); // R5

        // Transmit bit timing and Manchester encoding.
        take = (st_q.phase == endec_pkg::BIT_LAST);
        st_d.phase = take ? 2'h0 : st_q.phase + 2'h1; // R22
        st_d.taken = take;
        eof = st_q.tx_on && take && !mac_tx_en;
        if (take) begin
            st_d.tx_on = mac_tx_en;
            st_d.tx_bit = mac_tx_data;
        end
        line = (st_q.phase >= endec_pkg::BIT_HALF) ? st_q.tx_bit : !st_q.tx_bit; // R1
        tp_pkt = st_q.tx_on && st_q.tp_sel && link_ok; // R11 R13 R16
        if (st_q.lp_len != 3'h0) begin
            st_d.lp_len = st_q.lp_len - 3'h1;
        end
        if (st_q.tx_on || eof) begin
            st_d.lp_cnt = '0; // R10
        end else if (st_q.lp_cnt >= TW'(LP_PERIOD_CYC - 1)) begin
            st_d.lp_cnt = '0;
            if (!st_q.tp_pd) begin
                st_d.lp_len = endec_pkg::LP_LEN; // R9
            end
        end else begin
            st_d.lp_cnt = st_q.lp_cnt + 1'b1;
        end
        st_d.tp_en = tp_pkt || (st_q.lp_len != 3'h0); // R9 R11
        st_d.tp_out = tp_pkt ? line : 1'b1;
        aui_tx = st_q.tx_on && !st_q.tp_sel;
        st_d.aui_en = aui_tx; // R1
        st_d.aui_out = line;

        // Link integrity; zero counts mean a pulse or packet was just heard.
        if (lp_ev || pkt_ev) begin
            st_d.loss_cnt = '0; // R13
        end else if (st_q.loss_cnt != '1) begin
            st_d.loss_cnt = st_q.loss_cnt + 1'b1;
        end
        if (st_q.gap_cnt != '1) begin
            st_d.gap_cnt = st_q.gap_cnt + 1'b1;
        end
        case (st_q.link_st)
            endec_pkg::LINK_GOOD: begin
                if (!lp_ev && !pkt_ev && st_q.loss_cnt >= TW'(LINK_LOSS_CYC)) begin
                    st_d.link_st = endec_pkg::LINK_BAD; // R13
                end
            end
            endec_pkg::LINK_ARMED: begin
                if (pkt_ev || (lp_ev && st_q.gap_cnt > TW'(LP_MIN_GAP_CYC))) begin
                    st_d.link_st = endec_pkg::LINK_GOOD; // R14
                end else if (lp_ev) begin
                    st_d.gap_cnt = '0;
                end else if (st_q.gap_cnt >= TW'(LINK_LOSS_CYC)) begin
                    st_d.link_st = endec_pkg::LINK_BAD;
                end
            end
            endec_pkg::LINK_BAD: begin
                if (pkt_ev) begin
                    st_d.link_st = endec_pkg::LINK_GOOD; // R14
                end else if (lp_ev) begin
                    st_d.link_st = endec_pkg::LINK_ARMED;
                    st_d.gap_cnt = '0;
                end
            end
            default: begin
                st_d.link_st = endec_pkg::LINK_BAD;
            end
        endcase

        // Collisions; the 10 MHz collision tone is stretched to a steady level.
        if (st_q.ci2) begin
            st_d.ci_cnt = endec_pkg::CI_HOLD_CYC;
        end else if (st_q.ci_cnt != 4'h0) begin
            st_d.ci_cnt = st_q.ci_cnt - 4'h1;
        end
        st_d.col = (!st_q.test_ctl[endec_pkg::BIT_FDX] && tp_pkt && tp_act) || // R19
            (!st_q.tp_sel && st_q.ci_cnt != 4'h0); // R21

        // AUI echo check: carrier must appear and hold for the whole transmission.
        if (aui_tx) begin
            if (st_q.crs) begin
                st_d.aui_crs_seen = 1'b1;
            end else if (st_q.aui_crs_seen) begin
                loss_set = 1'b1; // R20
            end
        end else begin
            st_d.aui_crs_seen = 1'b0;
        end
        if (eof && !st_q.tp_sel && !st_q.aui_crs_seen && !st_q.crs) begin
            loss_set = 1'b1; // R20
        end

        // Register port; read data stand only in the cycle after the strobe.
        st_d.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                endec_pkg::REG_TX_EVENT: begin
                    st_d.rdata[endec_pkg::BIT_EV_LOSS] = st_q.carrier_lost_flag;
                end
                endec_pkg::REG_LINE_CTL: begin
                    st_d.rdata = st_q.line_ctl;
                end
                endec_pkg::REG_LINE_ST: begin
                    st_d.rdata[endec_pkg::BIT_ST_CRS] = st_q.crs; // R4
                    st_d.rdata[endec_pkg::BIT_ST_POL] = !st_q.reversed; // R17
                    st_d.rdata[endec_pkg::BIT_ST_LINK] =
                        (st_q.link_st == endec_pkg::LINK_GOOD); // R15
                end
                endec_pkg::REG_SELF_CTL: begin
                    st_d.rdata = st_q.self_ctl;
                end
                endec_pkg::REG_TEST_CTL: begin
                    st_d.rdata = st_q.test_ctl;
                end
                default: begin
                    st_d.rdata = 16'h0000;
                end
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                endec_pkg::REG_LINE_CTL: st_d.line_ctl = reg_wdata;
                endec_pkg::REG_SELF_CTL: st_d.self_ctl = reg_wdata;
                endec_pkg::REG_TEST_CTL: st_d.test_ctl = reg_wdata;
                default: st_d.line_ctl = st_q.line_ctl;
            endcase
        end
        // A new event in the clearing read cycle survives the clear.
        st_d.carrier_lost_flag = loss_set || (st_q.carrier_lost_flag &&
            !(reg_rd && reg_addr == endec_pkg::REG_TX_EVENT)); // R20
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0; // R23
            st_q.line_ctl <= endec_pkg::LINE_CTL_RST;
            st_q.self_ctl <= endec_pkg::SELF_CTL_RST;
            st_q.test_ctl <= endec_pkg::TEST_CTL_RST;
            st_q.tp_sel <= 1'b1;
            st_q.led <= 1'b1;
            st_q.link_st <= endec_pkg::LINK_BAD; // R23
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign tx_bit_taken = st_q.taken;
    assign mac_rx_data = st_q.rx_data;
    assign mac_rx_valid = st_q.rx_valid;
    assign mac_rx_clk = st_q.rx_clk;
    assign mac_crs = st_q.crs;
    assign mac_col = st_q.col;
    assign tp_tx_out = st_q.tp_out;
    assign tp_tx_en = st_q.tp_en;
    assign tp_power_down = st_q.tp_pd;
    assign tp_low_squelch = st_q.low_sq;
    assign aui_tx_out = st_q.aui_out;
    assign aui_tx_en = st_q.aui_en;
    assign aui_power_down = st_q.aui_pd;
    assign link_led_out = st_q.led;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_TP_TX_ACTIVE: assert property ( // R1
        st_q.tx_on && st_q.tp_sel && st_q.link_st == endec_pkg::LINK_GOOD |=> st_q.tp_en)
        else $error("Twisted-pair driver idle during good-link transmission.");
    AST_CRS_PATTERN: assert property ( // R2
        $rose(st_q.crs) && $past(st_q.tp_sel) |->
            st_q.pat == endec_pkg::PAT_A || st_q.pat == endec_pkg::PAT_B)
        else $error("Carrier rose without an alternating pattern.");
    AST_CRS_RELEASE: assert property ( // R3
        st_q.crs && st_q.since_edge >= endec_pkg::CRS_OFF_CYC |=> !st_q.crs)
        else $error("Carrier held past the release window.");
    AST_STATUS_CRS: assert property ( // R4
        reg_rd && reg_addr == endec_pkg::REG_LINE_ST |=>
            reg_rdata[endec_pkg::BIT_ST_CRS] == $past(st_q.crs))
        else $error("Status carrier bit does not match carrier sense.");
    AST_AUI_ONLY: assert property ( // R6
        st_q.line_ctl[endec_pkg::BIT_AUI_ONLY] |=> !st_q.tp_sel && st_q.tp_pd)
        else $error("AUI-only mode left twisted pair selected or powered.");
    AST_PULSE_WIDTH: assert property ( // R9
        $rose(st_q.lp_len != 3'h0) |-> (st_q.lp_len != 3'h0) [*4] ##1 (st_q.lp_len == 3'h0))
        else $error("Link pulse not one bit time wide.");
    AST_LINK_DROP: assert property ( // R13
        st_q.link_st == endec_pkg::LINK_GOOD && !lp_ev && !pkt_ev &&
            st_q.loss_cnt >= TW'(LINK_LOSS_CYC) |=> st_q.link_st == endec_pkg::LINK_BAD)
        else $error("Link stayed good after the loss timer expired.");
    AST_LINK_REARM: assert property ( // R14
        st_q.link_st == endec_pkg::LINK_ARMED && lp_ev && st_q.gap_cnt > TW'(LP_MIN_GAP_CYC)
            |=> st_q.link_st == endec_pkg::LINK_GOOD)
        else $error("Two spaced pulses did not restore the link.");
    AST_LED: assert property ( // R15
        !st_q.self_ctl[endec_pkg::BIT_LED_OVR] |=>
            st_q.led == ($past(st_q.link_st) != endec_pkg::LINK_GOOD))
        else $error("Link LED does not follow link state.");
    AST_HDX_COL: assert property ( // R19
        !st_q.test_ctl[endec_pkg::BIT_FDX] && tp_pkt && tp_act |=> mac_col)
        else $error("Half-duplex overlap gave no collision.");
    AST_LOSS_FLAG: assert property ( // R20
        eof && !st_q.tp_sel && !st_q.aui_crs_seen && !st_q.crs |=> st_q.carrier_lost_flag)
        else $error("Missing AUI echo not flagged.");

    COV_CRS: cover property ($rose(st_q.crs));
    COV_LINK_UP: cover property ($rose(st_q.link_st == endec_pkg::LINK_GOOD));
    COV_COL: cover property ($rose(mac_col));

endmodule // ten_mbit_endec_link_logic

// file: tp_link_partner.sv
// Purpose: Twisted-pair far end that sends link pulses and short frames.
// Assumes: Sliced receive levels, both low while the line is idle.
// Notes: A frame is 16 alternating data bits, then a positive end-of-frame level.
`timescale 1ns/1ps
module tp_link_partner (
    input wire logic ref_clk,
    input wire logic send_pulse,
    input wire logic send_frame,
    output logic tp_rx_pos,
    output logic tp_rx_neg
);
    int pulse_left = 0;
    int frame_cyc = -1;
    initial begin
        tp_rx_pos = 1'b0;
        tp_rx_neg = 1'b0;
    end
    always @(posedge ref_clk) begin
        if (send_pulse) pulse_left = 4;
        if (send_frame) frame_cyc = 0;
        if (frame_cyc >= 0 && frame_cyc < 64) begin
            // Data 1010 in Manchester: halves go low, high, high, low.
            tp_rx_pos <= frame_cyc[2] ^ frame_cyc[1];
            tp_rx_neg <= ~(frame_cyc[2] ^ frame_cyc[1]);
        end else if ((frame_cyc >= 64) || (pulse_left > 0)) begin
            tp_rx_pos <= 1'b1;
            tp_rx_neg <= 1'b0;
        end else begin
            // Released line reads as no signal on either slicer.
            tp_rx_pos <= 1'b0;
            tp_rx_neg <= 1'b0;
        end
        if (pulse_left > 0) pulse_left--;
        if (frame_cyc >= 0) frame_cyc = (frame_cyc < 67) ? frame_cyc + 1 : -1;
    end
endmodule // tp_link_partner

// file: tb_top.sv
// Purpose: Self-checking bench for the line coding and link logic.
// Assumes: Short link timers set by parameter so the run stays brief.
// Notes: Expected values come from integer reasoning on the register bits.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, aui_ci = 1'b0;
    logic send_pulse = 1'b0, send_frame = 1'b0, tp_rx_pos, tp_rx_neg, tp_tx_en, mac_col, mac_crs;
    logic tp_tx_out, tp_power_down, aui_power_down, tp_low_squelch, link_led_out;
    logic tx_en = 1'b0, tx_d = 1'b0, tx_taken;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, d, v;
    int n_fail = 0, checked = 0, seed = 63, cyc = 0, k;
    always #12.5 ref_clk = ~ref_clk;
    ten_mbit_endec_link_logic #(.LP_PERIOD_CYC(200), .LINK_LOSS_CYC(500),
        .LP_MIN_GAP_CYC(50)) dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mac_tx_en(tx_en), .mac_tx_data(tx_d), .tx_bit_taken(tx_taken), .mac_rx_data(),
        .mac_rx_valid(), .mac_rx_clk(), .mac_crs(mac_crs), .mac_col(mac_col),
        .tp_rx_pos(tp_rx_pos), .tp_rx_neg(tp_rx_neg), .tp_tx_out(tp_tx_out),
        .tp_tx_en(tp_tx_en), .tp_power_down(tp_power_down), .tp_low_squelch(tp_low_squelch),
        .aui_rx_pos(1'b0), .aui_rx_neg(1'b0), .aui_ci(aui_ci), .aui_tx_out(), .aui_tx_en(),
        .aui_power_down(aui_power_down), .link_led_out(link_led_out));
    tp_link_partner partner (.ref_clk(ref_clk), .send_pulse(send_pulse),
        .send_frame(send_frame), .tp_rx_pos(tp_rx_pos), .tp_rx_neg(tp_rx_neg));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] r);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask
    task automatic kick(input int which);
        if (which == 0) send_pulse <= 1'b1;
        else send_frame <= 1'b1;
        @(posedge ref_clk);
        send_pulse <= 1'b0;
        send_frame <= 1'b0;
        #1;
    endtask
    task automatic results;
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // A hang is cut short well beyond the thousand or so cycles the tests need.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(5'h0E, d);
        chk(d, 16'h1000);
        chk({15'h0, link_led_out}, 16'h0001);
        rd(5'h1F, d);
        chk(d, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = 16'($random(seed) & 32'h4000) | 16'((i % 4) << 8);
            wr(5'h0D, v);
            repeat (2) @(posedge ref_clk);
            #1;
            chk({13'h0, tp_power_down, aui_power_down, tp_low_squelch},
                {13'h0, v[8], v[9:8] == 2'b00, v[14]});
        end
        $display("test port select done");
        aui_ci <= 1'b1;
        for (k = 0; k < 8 && mac_col !== 1'b1; k++) @(posedge ref_clk) #1;
        #1 chk({15'h0, mac_col}, 16'h0001);
        aui_ci <= 1'b0;
        $display("test aui collision done");
        wr(5'h0D, 16'h0000);
        for (k = 0; k < 300 && tp_tx_en !== 1'b1; k++) @(posedge ref_clk) #1;
        #1 chk({15'h0, tp_tx_out}, 16'h0001);
        for (k = 0; k < 10 && tp_tx_en === 1'b1; k++) @(posedge ref_clk) #1;
        chk(16'(k), 16'h0004);
        $display("test link pulse done");
        kick(0);
        repeat (100) @(posedge ref_clk);
        kick(0);
        repeat (20) @(posedge ref_clk);
        rd(5'h0E, d);
        chk(d & 16'h1080, 16'h1080);
        chk({15'h0, link_led_out}, 16'h0000);
        repeat (600) @(posedge ref_clk);
        rd(5'h0E, d);
        chk(d & 16'h0080, 16'h0000);
        chk({15'h0, link_led_out}, 16'h0001);
        $display("test link integrity done");
        kick(1);
        repeat (30) @(posedge ref_clk);
        #1 chk({15'h0, mac_crs}, 16'h0001);
        rd(5'h0E, d);
        chk(d & 16'h4000, 16'h4000);
        // The last rising line edge lands five cycles before the check that follows.
        repeat (38) @(posedge ref_clk);
        #1 chk({15'h0, mac_crs}, 16'h0001);
        repeat (5) @(posedge ref_clk);
        #1 chk({15'h0, mac_crs}, 16'h0000);
        rd(5'h0E, d);
        chk(d, 16'h1080);
        $display("test frame receive done");
        tx_en <= 1'b1;
        tx_d <= 1'($random(seed));
        @(posedge ref_clk) #1;
        for (k = 0; k < 8 && tx_taken !== 1'b1; k++) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        chk({14'h0, tp_tx_en, tp_tx_out}, {14'h0, 1'b1, ~tx_d});
        repeat (2) @(posedge ref_clk);
        #1 chk({15'h0, tp_tx_out}, {15'h0, tx_d});
        tx_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk({15'h0, tp_tx_en}, 16'h0000);
        $display("test transmit done");
        results();
    end
endmodule // tb_top
